// >>> bench/tbm_pte_fetch_model.sv
`timescale 1ns/1ps
module tbm_pte_fetch_model (
    input  wire        sys_clk,        // clock
    input  wire        rst_b,          // reset, active low
    input  wire [1:0]  ackDelay,       // extra wait before answering
    input  wire        fetchReq,       // fetch request
    input  wire [31:0] fetchVa,        // page to fetch
    output reg         fetchAck,       // answer strobe
    output reg  [20:0] fetchPfn,       // frame number
    output reg         fetchPageValid, // page valid
    output reg         fetchPageMod,   // page modified
    output reg  [3:0]  fetchProt       // protection code
);
    reg [1:0] waitCnt;
    reg       answered; // one answer per request
    // data inverts every cycle except an answer cycle, so a value read one cycle late is the inverse of the answer
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetchAck <= 1'b0;
            waitCnt <= 2'h0;
            answered <= 1'b0;
            {fetchPageMod, fetchPageValid, fetchProt, fetchPfn} <= 27'h0;
        end else begin
            fetchAck <= 1'b0;
            {fetchPageMod, fetchPageValid, fetchProt, fetchPfn} <=
                ~{fetchPageMod, fetchPageValid, fetchProt, fetchPfn};
            if (!fetchReq) begin
                answered <= 1'b0;
                waitCnt <= 2'h0;
            end else if (!answered && waitCnt == ackDelay) begin
                fetchAck <= 1'b1;
                answered <= 1'b1;
                fetchPfn <= fetchVa[29:9] + 21'h000100;
                {fetchProt, fetchPageMod, fetchPageValid} <= fetchVa[14:9];
            end else if (!answered) begin
                waitCnt <= waitCnt + 2'h1;
            end
        end
    end
endmodule

// >>> bench/tbm_translation_buffer_bench.sv
`timescale 1ns/1ps
`include "tbmmu_defs.vh"
module tbm_translation_buffer_bench;
    reg         sys_clk, rst_b, xlatReq, iprWrite, iprRead;
    reg  [31:0] xlatVa, iprWdata;
    reg  [7:0]  iprNum;
    reg  [1:0]  ackDelay;
    wire        xlatDone, xlatHit, xlatPageValid, xlatPageMod, fetchReq, fetchAck;
    wire        fetchPageValid, fetchPageMod, pslOverflowSet, translationEnable;
    wire [31:0] xlatPa, fetchVa, iprRdata;
    wire [7:0]  xlatProt;
    wire [20:0] fetchPfn;
    wire [3:0]  fetchProt;
    integer     errTotal, checked, i;
    tbm_translation_buffer i_tbm_translation_buffer (.sys_clk(sys_clk), .rst_b(rst_b),
        .xlatReq(xlatReq), .xlatVa(xlatVa), .xlatDone(xlatDone), .xlatHit(xlatHit),
        .xlatPa(xlatPa), .xlatPageValid(xlatPageValid), .xlatPageMod(xlatPageMod),
        .xlatProt(xlatProt), .fetchReq(fetchReq), .fetchVa(fetchVa), .fetchAck(fetchAck),
        .fetchPfn(fetchPfn), .fetchPageValid(fetchPageValid), .fetchPageMod(fetchPageMod),
        .fetchProt(fetchProt), .iprWrite(iprWrite), .iprRead(iprRead), .iprNum(iprNum),
        .iprWdata(iprWdata), .iprRdata(iprRdata), .pslOverflowSet(pslOverflowSet),
        .translationEnable(translationEnable));
    tbm_pte_fetch_model i_tbm_pte_fetch_model (.sys_clk(sys_clk), .rst_b(rst_b),
        .ackDelay(ackDelay), .fetchReq(fetchReq), .fetchVa(fetchVa), .fetchAck(fetchAck),
        .fetchPfn(fetchPfn), .fetchPageValid(fetchPageValid),
        .fetchPageMod(fetchPageMod), .fetchProt(fetchProt));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // page numbers spread over bit 31 and the low end of the tag, bits 21:9
    function [31:0] vaOf(input [7:0] n);
        vaOf = {n[0], 9'h0, n, n[4:0], 9'h0ab};
    endfunction
    task end_of_test;
        begin
            if (errTotal == 0 && checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input [8*8-1:0] what);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errTotal = errTotal + 1;
                $display("FAIL %0t %0s got %h want %h", $time, what, got, exp);
            end
        end
    endtask
    // one register move; results settle just after the taking edge
    task internal_processor_register(input rd, input [7:0] num, input [31:0] data);
        begin
            @(posedge sys_clk);
            iprRead <= rd;
            iprWrite <= !rd;
            iprNum <= num;
            iprWdata <= data;
            @(posedge sys_clk);
            iprRead <= 1'b0;
            iprWrite <= 1'b0;
            #1;
        end
    endtask
    // request dropped at the taking edge so it is never re-taken
    task xlate(input [7:0] n, input hit, input on);
        reg [31:0] va;
        integer    k;
        begin
            va = vaOf(n);
            @(posedge sys_clk);
            xlatReq <= 1'b1;
            xlatVa <= va;
            ackDelay <= n[1:0];
            @(posedge sys_clk);
            xlatReq <= 1'b0;
            #1;
            for (k = 0; k < 40 && xlatDone !== 1'b1; k = k + 1) begin
                @(posedge sys_clk);
                #1;
            end
            if (xlatDone !== 1'b1) begin
                chk(32'h0, 32'h1, "timeout");
                end_of_test;
            end else if (!on) begin
                chk(xlatPa, va, "ident");
            end else begin
                chk({31'h0, xlatHit}, {31'h0, hit}, "hit");
                chk(xlatPa, {2'h0, va[29:9] + 21'h000100, va[8:0]}, "addr");
                chk({xlatProt, xlatPageMod, xlatPageValid},
                    {4'h1 << va[14:13], 4'h1 << va[12:11], va[10:9]}, "pte");
            end
        end
    endtask
    initial begin
        {rst_b, xlatReq, iprWrite, iprRead, ackDelay} = 5'h0;
        {xlatVa, iprWdata, iprNum} = 72'h0;
        errTotal = 0;
        checked = 0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        internal_processor_register(1'b1, `TBM_IPR_ENABLE, 32'h0);
        chk(iprRdata, 32'h0, "enrd");
        xlate(8'h05, 1'b0, 1'b0);
        internal_processor_register(1'b0, `TBM_IPR_ENABLE, 32'h1);
        internal_processor_register(1'b1, `TBM_IPR_ENABLE, 32'h0);
        chk(iprRdata, 32'h1, "enrd");
        for (i = 0; i < 28; i = i + 1) xlate(i[7:0], 1'b0, 1'b1);
        for (i = 0; i < 28; i = i + 1) xlate(i[7:0], 1'b1, 1'b1);
        xlate(8'h28, 1'b0, 1'b1);
        xlate(8'h00, 1'b0, 1'b1);
        xlate(8'h02, 1'b1, 1'b1);
        xlate(8'h01, 1'b0, 1'b1);
        xlate(8'h03, 1'b0, 1'b1);
        internal_processor_register(1'b0, `TBM_IPR_PROBE, vaOf(8'h02));
        chk({31'h0, pslOverflowSet}, 32'h1, "probe");
        internal_processor_register(1'b0, `TBM_IPR_INV_ONE, vaOf(8'h02) ^ 32'h1f0);
        internal_processor_register(1'b0, `TBM_IPR_PROBE, vaOf(8'h02));
        chk({31'h0, pslOverflowSet}, 32'h0, "probe");
        xlate(8'h05, 1'b1, 1'b1);
        xlate(8'h02, 1'b0, 1'b1);
        // every flushing register empties the buffer; writes carry 0, except 1 to the enable register
        for (i = 0; i < 8; i = i + 1) begin
            internal_processor_register(1'b0, i < 6 ? 8'h08 + i[7:0] : (i == 6 ? `TBM_IPR_ENABLE : `TBM_IPR_INV_ALL),
                {31'h0, i == 6});
            internal_processor_register(1'b0, `TBM_IPR_PROBE, vaOf(8'h07));
            chk({31'h0, pslOverflowSet}, 32'h0, "flush");
            xlate(8'h07, 1'b0, 1'b1);
            xlate(8'h07, 1'b1, 1'b1);
        end
        internal_processor_register(1'b0, `TBM_IPR_ENABLE, 32'h0);
        xlate(8'h09, 1'b0, 1'b0);
        end_of_test;
    end
endmodule

// >>> bench/tbm_translation_buffer_monitor.sv
`timescale 1ns/1ps
`include "tbmmu_defs.vh"
module tbm_translation_buffer_monitor (
    input wire        sys_clk,           // clock
    input wire        rst_b,             // reset, active low
    input wire        xlatReq,           // translate request
    input wire [31:0] xlatVa,            // virtual address
    input wire        xlatDone,          // answer strobe
    input wire [31:0] xlatPa,            // physical address
    input wire        xlatPageValid,     // page valid out
    input wire        fetchReq,          // fetch request
    input wire        fetchAck,          // fetch answer
    input wire [20:0] fetchPfn,          // fetched frame
    input wire        fetchPageValid,    // fetched page valid
    input wire        iprWrite,          // register write
    input wire        iprRead,           // register read
    input wire [7:0]  iprNum,            // register number
    input wire [31:0] iprWdata,          // write data
    input wire [31:0] iprRdata,          // read data
    input wire        pslOverflowSet,    // probe hit pulse
    input wire        translationEnable  // translation on
);
    // bit-select kept as a wire so $past sees a plain signal
    wire wrBit = iprWdata[0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence sFill; fetchReq && fetchAck; endsequence
    sequence sIdleReq; xlatReq && !xlatDone && !fetchReq; endsequence
    sequence sFlushAll; iprWrite && iprNum == `TBM_IPR_INV_ALL; endsequence
    sequence sProbeNext; !fetchAck ##1 iprWrite && iprNum == `TBM_IPR_PROBE; endsequence
    AST_FILL_DONE: assert property (sFill |=> xlatDone && !fetchReq)
        else $error("fill not answered");
    AST_FILL_DATA: assert property (sFill |=> xlatPa[29:9] == $past(fetchPfn)
        && xlatPageValid == $past(fetchPageValid)) else $error("fill data lost");
    AST_IDENTITY: assert property (sIdleReq ##0 !translationEnable
        |=> xlatDone && xlatPa == $past(xlatVa)) else $error("off not identity");
    AST_FETCH_START: assert property ($rose(fetchReq)
        |-> translationEnable && $past(xlatReq)) else $error("stray fetch");
    AST_DONE_PULSE: assert property (xlatDone |=> !xlatDone)
        else $error("done too long");
    AST_DONE_CAUSE: assert property (xlatDone
        |-> $past(xlatReq) || $past(fetchAck)) else $error("done uncaused");
    AST_ENABLE_WR: assert property (iprWrite && iprNum == `TBM_IPR_ENABLE
        |=> translationEnable == $past(wrBit)) else $error("enable not set");
    AST_ENABLE_RD: assert property (iprRead && iprNum == `TBM_IPR_ENABLE
        |=> iprRdata == {31'h0, $past(translationEnable)}) else $error("bad read");
    AST_PROBE_FLUSHED: assert property (sFlushAll ##1 sProbeNext
        |=> !pslOverflowSet) else $error("probe hit after flush");
endmodule
bind tbm_translation_buffer tbm_translation_buffer_monitor i_tbm_translation_buffer_monitor (
    .sys_clk(sys_clk), .rst_b(rst_b), .xlatReq(xlatReq), .xlatVa(xlatVa),
    .xlatDone(xlatDone), .xlatPa(xlatPa), .xlatPageValid(xlatPageValid),
    .fetchReq(fetchReq), .fetchAck(fetchAck), .fetchPfn(fetchPfn),
    .fetchPageValid(fetchPageValid), .iprWrite(iprWrite), .iprRead(iprRead),
    .iprNum(iprNum), .iprWdata(iprWdata), .iprRdata(iprRdata),
    .pslOverflowSet(pslOverflowSet), .translationEnable(translationEnable));

// >>> logic/tbm_protection_code_decode.v
`timescale 1ns/1ps
`include "tbmmu_defs.vh"
// ----------------------------------------------------------------
// protection code partial decode: one-hot split into two nibbles
// ----------------------------------------------------------------
module tbm_protection_code_decode (
    input  wire [`TBM_PROTECTION_CODE_W-1:0]  protCode,   // 4-bit protection code
    output wire [`TBM_DPROT_W-1:0] protDecoded // 8-bit decoded form
);
    // low half one-hot of bits 1:0, high half one-hot of bits 3:2;
    // keeps the access check to a pair of AND terms per mode
    assign protDecoded = {4'h1 << protCode[3:2], 4'h1 << protCode[1:0]};
endmodule

// >>> logic/tbm_translation_buffer.v
`timescale 1ns/1ps
`include "tbmmu_defs.vh"
// Contract
// - buffer holds 28 entries, fully associative, any page in any entry
// - entries serve process or system space, holding modified entries
// - any write to register 56 flushes the whole buffer
// - writes to registers 8 through 13 flush the whole buffer
// - each entry is a 23-bit tag plus 31-bit translation register
// - translation holds frame, page valid, modified, decoded protection_code, entry valid
// - all 28 tags compared in parallel against address bits 31:9
// - one match signals hit and translates from that entry
// - on miss fetch entry from memory, write at replacement pointer
// - pointer advances whenever the entry it selects is accessed
// - writing 0 to register 56 disables translation, 1 enables
// - reading register 56 returns the enable state
// - writing address to register 58 invalidates entries mapping it
// - writing 0 to register 57 invalidates every entry
// - writing address to register 63 sets status bit 1 if valid
// - invalidate and probe registers are write only; reads undefined
module tbm_translation_buffer (
    input  wire                      sys_clk,       // 25 MHz clock
    input  wire                      rst_b,         // async reset, active low
    input  wire                      xlatReq,       // translate request, level
    input  wire [31:0]               xlatVa,        // virtual address
    output wire                      xlatDone,      // answer valid
    output reg                       xlatHit,       // answer came from a hit
    output reg  [31:0]               xlatPa,        // physical address
    output reg                       xlatPageValid, // page valid bit
    output reg                       xlatPageMod,   // page modified bit
    output reg  [`TBM_DPROT_W-1:0]   xlatProt,      // decoded protection
    output wire                      fetchReq,      // entry fetch request
    output wire [31:0]               fetchVa,       // address being fetched
    input  wire                      fetchAck,      // entry returned, pulse
    input  wire [`TBM_PFN_W-1:0]     fetchPfn,      // frame number
    input  wire                      fetchPageValid,// page valid
    input  wire                      fetchPageMod,  // page modified
    input  wire [`TBM_PROTECTION_CODE_W-1:0]    fetchProt,     // 4-bit protection
    input  wire                      iprWrite,      // register move write
    input  wire                      iprRead,       // register move read
    input  wire [`TBM_IPR_W-1:0]     iprNum,        // register number
    input  wire [31:0]               iprWdata,      // write data
    output reg  [31:0]               iprRdata,      // read data
    output reg                       pslOverflowSet,// set status bit 1, pulse
    output wire                      translationEnable // translation on
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg  [`TBM_TAG_W-1:0]  tagMem  [0:`TBM_ENTRIES-1];
    reg  [`TBM_XLAT_W-1:0] xlatMem [0:`TBM_ENTRIES-1];
    reg  [1:0]             state_reg;
    reg  [1:0]             state_next;
    reg  [`TBM_IDX_W-1:0]  replPtr_reg;
    reg                    enable_reg;
    reg                    doneFlag_reg;
    reg  [31:0]            missVa_reg;
    wire [`TBM_DPROT_W-1:0] fetchProtDec;
    wire [`TBM_TAG_W-1:0]  reqVpn;
    wire [`TBM_TAG_W-1:0]  wrVpn;
    reg  [`TBM_ENTRIES-1:0] hitVec;
    reg  [`TBM_ENTRIES-1:0] wrHitVec;
    reg                    anyHit;
    reg  [`TBM_IDX_W-1:0]  hitIdx;
    reg  [`TBM_XLAT_W-1:0] hitXlat;
    wire                   wrEnable;
    wire                   wrBase;
    wire                   wrInvAll;
    wire                   wrInvOne;
    wire                   wrProbe;
    wire                   flushAll;
    wire                   lookup;
    wire                   fillNow;
    wire [`TBM_DPROT_W-2:0] fetchProtKeep;
    wire [`TBM_DPROT_W-1:0] hitProtFull;
    wire [31:0]            hitPa;
    wire [31:0]            fillPa;
    integer                i;
    integer                j;

    assign reqVpn   = xlatVa[`TBM_VA_HI:`TBM_VA_LO];
    assign wrVpn    = iprWdata[`TBM_VA_HI:`TBM_VA_LO];
    assign translationEnable = enable_reg;
    assign fetchReq = (state_reg == `TBM_ST_FETCH);
    assign fetchVa  = missVa_reg;
    assign xlatDone = doneFlag_reg;

    // ----------------------------------------------------------------
    // register move decode
    // ----------------------------------------------------------------
    assign wrEnable = iprWrite && (iprNum == `TBM_IPR_ENABLE);
    assign wrBase   = iprWrite && (iprNum >= `TBM_IPR_BASE_LO)
                               && (iprNum <= `TBM_IPR_BASE_HI);
    // any written value counts; only 0 is defined for software
    assign wrInvAll = iprWrite && (iprNum == `TBM_IPR_INV_ALL);
    assign wrInvOne = iprWrite && (iprNum == `TBM_IPR_INV_ONE);
    assign wrProbe  = iprWrite && (iprNum == `TBM_IPR_PROBE);
    assign flushAll = wrEnable || wrBase || wrInvAll;

    tbm_protection_code_decode uProtDec (
        .protCode    (fetchProt),
        .protDecoded (fetchProtDec)
    );

    // ----------------------------------------------------------------
    // decoded protection pack and unpack, address assembly
    // ----------------------------------------------------------------
    // entry valid, both status bits, the frame and the full 8-bit decode
    // would need 32 bits; the register has 31, so the top decode bit is
    // left out and rebuilt on a hit: the high nibble is one-hot, so its
    // top bit is set exactly when the three below it are all clear
    assign fetchProtKeep = fetchProtDec[`TBM_DPROT_W-2:0];
    assign hitProtFull   = {~|hitXlat[`TBM_XL_PROTECTION_CODE_HI:`TBM_XL_ONEHOT_LO],
                            hitXlat[`TBM_XL_PROTECTION_CODE_HI:`TBM_XL_PROTECTION_CODE_LO]};

    // frame number over the page offset; address bits above the frame read zero
    assign hitPa  = {{`TBM_PA_PAD_W{1'b0}}, hitXlat[`TBM_XL_PFN_HI:`TBM_XL_PFN_LO],
                     xlatVa[`TBM_VA_LO-1:0]};
    assign fillPa = {{`TBM_PA_PAD_W{1'b0}}, fetchPfn, missVa_reg[`TBM_VA_LO-1:0]};

    // ----------------------------------------------------------------
    // parallel tag compare
    // ----------------------------------------------------------------
    // valid-qualified compare
    always @* begin
        anyHit  = 1'b0;
        hitIdx  = `TBM_IDX_ZERO;
        hitXlat = {`TBM_XLAT_W{1'b0}};
        for (i = 0; i < `TBM_ENTRIES; i = i + 1) begin
            hitVec[i]   = xlatMem[i][`TBM_XLAT_W-1] && (tagMem[i] == reqVpn);
            wrHitVec[i] = xlatMem[i][`TBM_XLAT_W-1] && (tagMem[i] == wrVpn);
            if (hitVec[i] && !anyHit) begin
                anyHit  = 1'b1;
                hitIdx  = i[`TBM_IDX_W-1:0];
                hitXlat = xlatMem[i];
            end
        end
    end

    // a lookup only starts from idle, with translation on and no answer pending
    assign lookup  = (state_reg == `TBM_ST_IDLE) && xlatReq && !doneFlag_reg
                     && enable_reg;
    assign fillNow = (state_reg == `TBM_ST_FETCH) && fetchAck;

    // ----------------------------------------------------------------
    // walk state machine
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `TBM_ST_IDLE: begin
                if (lookup && !anyHit) begin
                    state_next = `TBM_ST_FETCH;
                end
            end
            `TBM_ST_FETCH: begin
                if (fetchAck) begin
                    state_next = `TBM_ST_FILL;
                end
            end
            `TBM_ST_FILL: begin
                state_next = `TBM_ST_IDLE;
            end
            default: begin
                state_next = `TBM_ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= `TBM_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // entry array: fill, flush, single invalidate
    // ----------------------------------------------------------------
    // flush beats a same-cycle fill, so stale data never survives
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (j = 0; j < `TBM_ENTRIES; j = j + 1) begin
                tagMem[j]  <= {`TBM_TAG_W{1'b0}};
                xlatMem[j] <= {`TBM_XLAT_W{1'b0}};
            end
        end else begin
            for (j = 0; j < `TBM_ENTRIES; j = j + 1) begin
                if (flushAll) begin
                    xlatMem[j][`TBM_XLAT_W-1] <= 1'b0;
                end else if (wrInvOne && wrHitVec[j]) begin
                    xlatMem[j][`TBM_XLAT_W-1] <= 1'b0;
                end else if (fillNow && (replPtr_reg == j[`TBM_IDX_W-1:0])) begin
                    tagMem[j]  <= missVa_reg[`TBM_VA_HI:`TBM_VA_LO];
                    xlatMem[j] <= {1'b1, fetchProtKeep, fetchPageMod,
                                   fetchPageValid, fetchPfn};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // replacement pointer
    // ----------------------------------------------------------------
    // not last used advance
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            replPtr_reg <= `TBM_IDX_ZERO;
        end else if (fillNow || (lookup && anyHit && hitIdx == replPtr_reg)) begin
            if (replPtr_reg == `TBM_IDX_LAST) begin
                replPtr_reg <= `TBM_IDX_ZERO;
            end else begin
                replPtr_reg <= replPtr_reg + `TBM_IDX_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // translation answer
    // ----------------------------------------------------------------
    // answer holds one cycle; requester drops xlatReq before asking again
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            doneFlag_reg  <= 1'b0;
            xlatHit       <= 1'b0;
            xlatPa        <= 32'h0000_0000;
            xlatPageValid <= 1'b0;
            xlatPageMod   <= 1'b0;
            xlatProt      <= {`TBM_DPROT_W{1'b0}};
            missVa_reg    <= 32'h0000_0000;
        end else begin
            doneFlag_reg <= 1'b0;
            if (xlatReq && !doneFlag_reg && !enable_reg
                && state_reg == `TBM_ST_IDLE) begin
                // translation off: physical equals virtual
                doneFlag_reg  <= 1'b1;
                xlatHit       <= 1'b0;
                xlatPa        <= xlatVa;
                xlatPageValid <= 1'b1;
                xlatPageMod   <= 1'b0;
                xlatProt      <= {`TBM_DPROT_W{1'b0}};
            end else if (lookup && anyHit) begin
                doneFlag_reg  <= 1'b1;
                xlatHit       <= 1'b1;
                xlatPa        <= hitPa;
                xlatPageValid <= hitXlat[`TBM_XL_PV];
                xlatPageMod   <= hitXlat[`TBM_XL_PM];
                xlatProt      <= hitProtFull;
            end else if (lookup) begin
                missVa_reg <= xlatVa;
            end else if (fillNow) begin
                doneFlag_reg  <= 1'b1;
                xlatHit       <= 1'b0;
                xlatPa        <= fillPa;
                xlatPageValid <= fetchPageValid;
                xlatPageMod   <= fetchPageMod;
                xlatProt      <= fetchProtDec;
            end
        end
    end

    // ----------------------------------------------------------------
    // enable register, reads, probe
    // ----------------------------------------------------------------
    // enable from bit 0
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_reg <= 1'b0;
        end else if (wrEnable) begin
            enable_reg <= iprWdata[0];
        end
    end

    // read path; write-only numbers read zero
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            iprRdata <= 32'h0000_0000;
        end else if (iprRead) begin
            if (iprNum == `TBM_IPR_ENABLE) begin
                iprRdata <= {31'h0000_0000, enable_reg};
            end else begin
                iprRdata <= 32'h0000_0000;
            end
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pslOverflowSet <= 1'b0;
        end else begin
            pslOverflowSet <= wrProbe && (|wrHitVec);
        end
    end
endmodule

// >>> logic/tbmmu_defs.vh
`ifndef TBMMU_DEFS_VH
`define TBMMU_DEFS_VH
// ----------------------------------------------------------------
// register numbers
// ----------------------------------------------------------------
`define TBM_IPR_W            8
`define TBM_IPR_ENABLE       8'h38
`define TBM_IPR_INV_ALL      8'h39
`define TBM_IPR_INV_ONE      8'h3a
`define TBM_IPR_PROBE        8'h3f
`define TBM_IPR_BASE_LO      8'h08
`define TBM_IPR_BASE_HI      8'h0d
// ----------------------------------------------------------------
// geometry and field layout
// ----------------------------------------------------------------
`define TBM_ENTRIES          28
`define TBM_IDX_W            5
`define TBM_IDX_LAST         5'h1b
`define TBM_IDX_ZERO         5'h00
`define TBM_IDX_ONE          5'h01
`define TBM_TAG_W            23
`define TBM_VA_HI            31
`define TBM_VA_LO            9
`define TBM_XLAT_W           31
`define TBM_PFN_W            21
`define TBM_PROTECTION_CODE_W           4
`define TBM_DPROT_W          8
// translation register: [30] entry valid, [29:23] decoded protection_code less its
// top bit, [22] page modified, [21] page valid, [20:0] frame number
`define TBM_XL_PFN_HI        20
`define TBM_XL_PFN_LO        0
`define TBM_XL_PV            21
`define TBM_XL_PM            22
`define TBM_XL_PROTECTION_CODE_HI       29
`define TBM_XL_PROTECTION_CODE_LO       23
`define TBM_XL_ONEHOT_LO     27
`define TBM_PA_PAD_W         2
`define TBM_PSL_OVF          1
// ----------------------------------------------------------------
// walk states
// ----------------------------------------------------------------
`define TBM_ST_IDLE          2'h0
`define TBM_ST_FETCH         2'h1
`define TBM_ST_FILL          2'h2
`endif
